/* logic/ring_pkg.sv */
// Constants for the ring detector and ring validator
package ring_pkg;

  // ------------------------------------------------------------
  // Register indices (address port carries the index directly)
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL2  = 8'h02;
  localparam logic [7:0] REG_MASK   = 8'h03;
  localparam logic [7:0] REG_FLAG   = 8'h04;
  localparam logic [7:0] REG_STAT   = 8'h05;
  localparam logic [7:0] REG_PINCFG = 8'h0e;
  localparam logic [7:0] REG_THR_LO = 8'h10;
  localparam logic [7:0] REG_THR_HI = 8'h11;
  localparam logic [7:0] REG_MODE   = 8'h12;
  localparam logic [7:0] REG_HFLIM  = 8'h16;
  localparam logic [7:0] REG_DUR    = 8'h17;
  localparam logic [7:0] REG_LFLIM  = 8'h18;
  localparam logic [7:0] REG_DELAY  = 8'h1a;
  localparam logic [7:0] REG_INTCFG = 8'h1b;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BOTH_EDGES_BIT = 2;
  localparam int RING_IRQ_BIT   = 7;
  localparam int STAT_RDT_BIT   = 2;
  localparam int STAT_POS_BIT   = 5;
  localparam int STAT_NEG_BIT   = 6;
  localparam int POLARITY_BIT   = 1;
  localparam int THR_LO_BIT     = 0;
  localparam int THR_HI_BIT     = 4;
  localparam int FULL_WAVE_BIT  = 1;
  localparam int VAL_EN_BIT     = 7;
  localparam int INT_POL_BIT    = 0;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ------------------------------------------------------------
  // Ring data sample values
  // ------------------------------------------------------------
  localparam logic [15:0] SAMPLE_POS  = 16'h7fff;
  localparam logic [15:0] SAMPLE_NEG  = 16'h8000;
  localparam logic [15:0] SAMPLE_IDLE = 16'h04cc;

  // ------------------------------------------------------------
  // Timing: one validator tick is 2 ms at 10 ns per clock
  // ------------------------------------------------------------
  localparam int CLK_NS       = 10;
  localparam int TICK_NS      = 2_000_000;
  localparam int TICK_CYC     = TICK_NS / CLK_NS;
  localparam int ONESHOT_MS   = 5000;
  // Scaled to microseconds first so the product stays inside 32 bits
  localparam int ONESHOT_TCK  = ONESHOT_MS * 1000 / (TICK_NS / 1000);
  localparam int DUR_SHIFT    = 6;
  localparam int RTO_SHIFT    = 6;
  localparam int DLY_SHIFT    = 7;

endpackage

/* logic/ring_detect.sv */
// Ring detector, ring validator, status registers and ring samples
//
// Overview of operation
// - Mode bit 0 detects positive rings only; 1 detects both polarities.
// - Indicator pin is open drain, active low unless polarity bit set.
// - Half-wave asserts pin on positive ring; full-wave on either polarity.
// - Positive flag above positive threshold, negative flag below negative.
// - Detect status set by positive ring, or either polarity in full-wave.
// - Detect status is retriggerable one-shot, clearing after about 5 s.
// - An off-hook event clears the detect status.
// - Masked ring event drives interrupt pin; host clears by writing flag.
// - Interrupt on rising status edge, or both edges when selected.
// - Ring samples replace transmit data only when powered, on-hook, idle.
// - Half-wave samples: -32768 idle or negative, +32767 when positive.
// - Full-wave samples: +1228 idle, +32767 positive, -32768 negative.
// - Validator times alternating crossings against low and high limits.
// - After duration check passes, watch for ring end timeout only.
// - Delay timer from first validation must expire before ring timeout.
// - Validation enable bit switches validation on or off.
// - With validation, status shows envelope; interrupt only valid rings.
// - Interrupt pin follows interrupt flag with selectable polarity.
// - With validation, pin follows envelope, or one-shot in full-wave.
// - Two select bits choose one of four comparator thresholds.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ring_detect #(
  parameter int TICK_CYC = ring_pkg::TICK_CYC
) (
  input  wire logic        clk_sys,         // System clock, 100 MHz
  input  wire logic        nrst,            // Async reset, active low
  input  wire logic [7:0]  addr,            // Register index
  input  wire logic [7:0]  wdata,           // Write data
  input  wire logic        wr,              // Write strobe
  input  wire logic        rd,              // Read strobe
  output logic      [7:0]  rdata,           // Read data, cycle after rd
  input  wire logic        cmp_pos,         // Sense above positive threshold
  input  wire logic        cmp_neg,         // Sense below negative threshold
  output logic      [1:0]  thr_sel,         // Threshold level to comparators
  input  wire logic        off_hook,        // Line is off-hook
  input  wire logic        onhook_monitor,  // On-hook line monitor mode
  input  wire logic        isolation_link_powerdown, // Link powered down
  input  wire logic [15:0] tx_sample,       // Transmit path sample
  input  wire logic        tx_valid,        // Transmit sample strobe
  output logic      [15:0] serial_transmit_samples, // Outgoing sample
  output logic             sample_valid,    // Outgoing sample strobe
  output logic             ring_indicator_pin_o,  // Pin drive level (0)
  output logic             ring_indicator_pin_oe, // Pin pull-down enable
  output logic             interrupt_pin    // Interrupt output
);

  typedef enum logic [1:0] {
    V_IDLE = 2'b00,
    V_FREQ = 2'b01,
    V_TAIL = 2'b10
  } vstate_e;

  typedef enum logic [1:0] {
    P_NONE = 2'b00,
    P_POS  = 2'b01,
    P_NEG  = 2'b10
  } pol_e;

  typedef struct packed {
    logic [17:0] tick_cnt;
    logic        tick;
    logic [11:0] os_cnt;
    logic        pos;
    logic        neg;
    logic [7:0]  ctrl2;
    logic [7:0]  mask;
    logic        flag;
    logic [7:0]  pincfg;
    logic [7:0]  thr_lo;
    logic [7:0]  thr_hi;
    logic [7:0]  mode;
    logic [7:0]  hflim;
    logic [7:0]  dur;
    logic [7:0]  lflim;
    logic [7:0]  delay;
    logic [7:0]  intcfg;
    logic        rdt_prev;
    logic        hook_prev;
    vstate_e     st;
    pol_e        last;
    logic [6:0]  hp;
    logic [9:0]  dur_cnt;
    logic [10:0] rto_cnt;
    logic [9:0]  dly_cnt;
    logic        dly_on;
    logic        env;
    logic [7:0]  rdata;
    logic        ri_oe;
    logic        int_pin;
    logic [1:0]  thr_sel;
    logic [15:0] sample;
    logic        sample_vld;
  } state_s;

  state_s q;
  state_s d;

  logic        full_wave;
  logic        val_en;
  logic        det;
  logic        oneshot;
  logic        rdt_eff;
  logic        enter;
  logic        alt;
  logic        ri_active;
  logic [9:0]  dur_lim;
  logic [10:0] rto_lim;
  logic [9:0]  dly_lim;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    d = q;
    full_wave = q.mode[ring_pkg::FULL_WAVE_BIT];
    val_en    = q.lflim[ring_pkg::VAL_EN_BIT];
    dur_lim = 10'((11'(q.dur[2:0]) + 11'd1) << ring_pkg::DUR_SHIFT);
    rto_lim = 11'((12'(q.dur[6:3]) + 12'd1) << ring_pkg::RTO_SHIFT);
    dly_lim = 10'(10'(q.delay[2:0]) << ring_pkg::DLY_SHIFT);

    // Fixed time base, independent of operating mode
    d.tick = 1'b0;
    if (q.tick_cnt == 18'(TICK_CYC - 1)) begin
      d.tick_cnt = 18'h00000;
      d.tick = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 18'h00001;
    end

    // Comparator flags; both at once is treated as neither
    d.pos = cmp_pos & ~cmp_neg;
    d.neg = cmp_neg & ~cmp_pos;
    d.thr_sel = {q.thr_hi[ring_pkg::THR_HI_BIT],
                 q.thr_lo[ring_pkg::THR_LO_BIT]};

    det = q.pos | (full_wave & q.neg);

    // Retriggerable one-shot
    d.hook_prev = off_hook;
    if (det) begin
      d.os_cnt = 12'(ring_pkg::ONESHOT_TCK);
    end else if (q.tick && q.os_cnt != 12'h000) begin
      d.os_cnt = q.os_cnt - 12'h001;
    end
    if (off_hook && !q.hook_prev) begin
      d.os_cnt = 12'h000;
    end
    oneshot = (q.os_cnt != 12'h000);

    // Validator: alternating threshold crossings
    enter = (d.pos & ~q.pos) | (d.neg & ~q.neg);
    alt = (d.pos & ~q.pos & (q.last == P_NEG)) |
          (d.neg & ~q.neg & (q.last == P_POS));
    if (enter) begin
      d.last = d.pos ? P_POS : P_NEG;
    end

    if (q.dly_on && q.tick) begin
      d.dly_cnt = q.dly_cnt + 10'h001;
    end
    if (q.dly_on && q.dly_cnt >= dly_lim) begin
      d.env = 1'b1;
      d.dly_on = 1'b0;
    end

    unique case (q.st)
      V_IDLE: begin
        d.hp = 7'h00;
        d.dur_cnt = 10'h000;
        if (enter) begin
          d.st = V_FREQ;
        end
      end
      V_FREQ: begin
        if (q.tick && q.hp != 7'h7f) begin
          d.hp = q.hp + 7'h01;
        end
        if (q.tick && q.dur_cnt != 10'h3ff) begin
          d.dur_cnt = q.dur_cnt + 10'h001;
        end
        if (q.hp > {1'b0, q.lflim[5:0]}) begin
          // Half period too long: frequency below the low limit
          d.st = V_IDLE;
          d.last = P_NONE;
          d.dly_on = 1'b0;
        end else if (alt) begin
          d.hp = 7'h00;
          if (q.hp < {1'b0, q.hflim[5:0]}) begin
            d.st = V_IDLE;
            d.last = P_NONE;
            d.dly_on = 1'b0;
          end else if (!q.dly_on && !q.env) begin
            d.dly_on = 1'b1;
            d.dly_cnt = 10'h000;
          end
        end
        if (q.dur_cnt >= dur_lim && (q.dly_on || q.env)) begin
          d.st = V_TAIL;
          d.rto_cnt = 11'h000;
        end
      end
      V_TAIL: begin
        if (enter) begin
          d.rto_cnt = 11'h000;
        end else if (q.tick) begin
          d.rto_cnt = q.rto_cnt + 11'h001;
        end
        if (q.rto_cnt >= rto_lim) begin
          // Ring end; an unexpired delay means no valid ring
          d.st = V_IDLE;
          d.env = 1'b0;
          d.dly_on = 1'b0;
          d.last = P_NONE;
        end
      end
      default: begin
        d.st = V_IDLE;
      end
    endcase

    if (!val_en || (off_hook && !q.hook_prev)) begin
      d.st = V_IDLE;
      d.env = 1'b0;
      d.dly_on = 1'b0;
      d.last = P_NONE;
    end

    // Status seen by software and by the interrupt edge logic
    rdt_eff = val_en ? q.env : oneshot;
    d.rdt_prev = rdt_eff;

    // Indicator pin: open drain only ever pulls low
    if (val_en) begin
      ri_active = full_wave ? oneshot : q.env;
    end else begin
      ri_active = det;
    end
    d.ri_oe = q.pincfg[ring_pkg::POLARITY_BIT] ? ~ri_active
                                               : ri_active;

    // Register writes
    if (wr) begin
      unique case (addr)
        ring_pkg::REG_CTRL2:  d.ctrl2  = wdata;
        ring_pkg::REG_MASK:   d.mask   = wdata;
        ring_pkg::REG_PINCFG: d.pincfg = wdata;
        ring_pkg::REG_THR_LO: d.thr_lo = wdata;
        ring_pkg::REG_THR_HI: d.thr_hi = wdata;
        ring_pkg::REG_MODE:   d.mode   = wdata;
        ring_pkg::REG_HFLIM:  d.hflim  = wdata;
        ring_pkg::REG_DUR:    d.dur    = wdata;
        ring_pkg::REG_LFLIM:  d.lflim  = wdata;
        ring_pkg::REG_DELAY:  d.delay  = wdata;
        ring_pkg::REG_INTCFG: d.intcfg = wdata;
        ring_pkg::REG_FLAG: begin
          if (!wdata[ring_pkg::RING_IRQ_BIT]) begin
            d.flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Event sets the flag; a same-cycle clear loses
    if ((rdt_eff && !q.rdt_prev) ||
        (!rdt_eff && q.rdt_prev &&
         q.ctrl2[ring_pkg::BOTH_EDGES_BIT])) begin
      d.flag = 1'b1;
    end
    d.int_pin = (q.flag & q.mask[ring_pkg::RING_IRQ_BIT]) ^
                q.intcfg[ring_pkg::INT_POL_BIT];

    // Register reads
    d.rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        ring_pkg::REG_CTRL2:  d.rdata = q.ctrl2;
        ring_pkg::REG_MASK:   d.rdata = q.mask;
        ring_pkg::REG_FLAG:
          d.rdata = 8'(q.flag) << ring_pkg::RING_IRQ_BIT;
        ring_pkg::REG_STAT: begin
          d.rdata[ring_pkg::STAT_RDT_BIT] = rdt_eff;
          d.rdata[ring_pkg::STAT_POS_BIT] = q.pos;
          d.rdata[ring_pkg::STAT_NEG_BIT] = q.neg;
        end
        ring_pkg::REG_PINCFG: d.rdata = q.pincfg;
        ring_pkg::REG_THR_LO: d.rdata = q.thr_lo;
        ring_pkg::REG_THR_HI: d.rdata = q.thr_hi;
        ring_pkg::REG_MODE:   d.rdata = q.mode;
        ring_pkg::REG_HFLIM:  d.rdata = q.hflim;
        ring_pkg::REG_DUR:    d.rdata = q.dur;
        ring_pkg::REG_LFLIM:  d.rdata = q.lflim;
        ring_pkg::REG_DELAY:  d.rdata = q.delay;
        ring_pkg::REG_INTCFG: d.rdata = q.intcfg;
        default:              d.rdata = 8'h00;
      endcase
    end

    // Sample stream: ring data takes the place of transmit data
    d.sample_vld = tx_valid;
    if (!isolation_link_powerdown && !off_hook && !onhook_monitor) begin
      if (q.pos) begin
        d.sample = ring_pkg::SAMPLE_POS;
      end else if (full_wave && q.neg) begin
        d.sample = ring_pkg::SAMPLE_NEG;
      end else if (full_wave) begin
        d.sample = ring_pkg::SAMPLE_IDLE;
      end else begin
        d.sample = ring_pkg::SAMPLE_NEG;
      end
    end else begin
      d.sample = tx_sample;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign rdata                   = q.rdata;
  assign thr_sel                 = q.thr_sel;
  assign serial_transmit_samples = q.sample;
  assign sample_valid            = q.sample_vld;
  assign ring_indicator_pin_o    = q.tick & 1'b0;
  assign ring_indicator_pin_oe   = q.ri_oe;
  assign interrupt_pin           = q.int_pin;

endmodule

`default_nettype wire

/* sim/ring_detect_chk.sv */
// Port-level assertions for the ring detector
`timescale 1ns/1ps
`default_nettype none

module ring_detect_chk (
  input wire logic        clk_sys, // Clock
  input wire logic        nrst, // Reset, active low
  input wire logic [7:0]  addr, // Register index
  input wire logic        wr, // Write strobe
  input wire logic        rd, // Read strobe
  input wire logic [7:0]  rdata, // Read data
  input wire logic        cmp_pos, // Above positive threshold
  input wire logic        cmp_neg, // Below negative threshold
  input wire logic [1:0]  thr_sel, // Threshold select
  input wire logic        off_hook, // Off-hook
  input wire logic        onhook_monitor, // Monitor mode
  input wire logic        isolation_link_powerdown, // Link down
  input wire logic [15:0] tx_sample, // Transmit sample
  input wire logic [15:0] serial_transmit_samples, // Outgoing sample
  input wire logic        ring_indicator_pin_o // Pin drive level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic ring_ok;
  logic pos_only;
  logic neg_only;
  logic quiet;
  logic thr_wr;
  assign ring_ok  = !off_hook && !onhook_monitor &&
                    !isolation_link_powerdown;
  assign pos_only = cmp_pos && !cmp_neg;
  assign neg_only = cmp_neg && !cmp_pos;
  assign quiet    = !cmp_pos && !cmp_neg;
  assign thr_wr   = wr && (addr == ring_pkg::REG_THR_LO ||
                           addr == ring_pkg::REG_THR_HI);

  // Idle comparators around the event, so no detection can retrigger
  sequence s_hook_read;
    quiet ##1 (quiet throughout
      ($rose(off_hook) ##2 (rd && addr == ring_pkg::REG_STAT)));
  endsequence

  AST_DRIVE_LOW: assert property (!ring_indicator_pin_o)
    else $error("indicator drive level not low");
  AST_POS_DATA: assert property ((ring_ok && pos_only) [*3]
    |=> serial_transmit_samples == ring_pkg::SAMPLE_POS)
    else $error("positive ring sample wrong");
  AST_NEG_DATA: assert property ((ring_ok && neg_only) [*3]
    |=> serial_transmit_samples == ring_pkg::SAMPLE_NEG)
    else $error("negative ring sample wrong");
  AST_IDLE_DATA: assert property ((ring_ok && quiet) [*3]
    |=> serial_transmit_samples inside
        {ring_pkg::SAMPLE_NEG, ring_pkg::SAMPLE_IDLE})
    else $error("idle ring sample wrong");
  AST_PASS_DATA: assert property ((!ring_ok) [*2]
    |=> serial_transmit_samples == $past(tx_sample))
    else $error("transmit sample not passed through");
  AST_FLAGS: assert property (rd && addr == ring_pkg::REG_STAT
    && $past(nrst) && $stable(cmp_pos) && $stable(cmp_neg)
    |=> rdata[ring_pkg::STAT_POS_BIT] == $past(pos_only)
        && rdata[ring_pkg::STAT_NEG_BIT] == $past(neg_only))
    else $error("ring flags do not match comparators");
  AST_THR_SRC: assert property ($changed(thr_sel)
    |-> $past(thr_wr) || $past(thr_wr, 2))
    else $error("threshold select moved without a write");
  AST_HOOK_CLEAR: assert property (s_hook_read
    |=> !rdata[ring_pkg::STAT_RDT_BIT])
    else $error("detect status survived off-hook");

  cover property ((ring_ok && pos_only) [*3]);
  cover property (s_hook_read);
  cover property ($changed(thr_sel));
endmodule

bind ring_detect ring_detect_chk u_chk (.clk_sys, .nrst, .addr, .wr, .rd,
  .rdata, .cmp_pos, .cmp_neg, .thr_sel, .off_hook, .onhook_monitor,
  .isolation_link_powerdown, .tx_sample, .serial_transmit_samples,
  .ring_indicator_pin_o);
`default_nettype wire

/* sim/ring_host.sv */
// Host processor model on the register port
`timescale 1ns/1ps
`default_nettype none

module ring_host (
  input  wire logic       clk_sys, // Clock
  output logic      [7:0] addr, // Register index
  output logic      [7:0] wdata, // Write data
  output logic            wr, // Write strobe
  output logic            rd, // Read strobe
  input  wire logic [7:0] rdata // Read data
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // Each access ends with an idle cycle so a strobe never drops and
  // rises again in one time step
  task automatic bus_write(input logic [7:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [7:0] v);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask

  task automatic clear_ring_irq;
    bus_write(ring_pkg::REG_FLAG, 8'h00);
  endtask
endmodule
`default_nettype wire

/* sim/ring_detect_tb.sv */
// Self-checking bench for the ring detector and validator
`timescale 1ns/1ps
`default_nettype none

module ring_detect_tb;
  localparam int TK = 4;
  localparam int OS = ring_pkg::ONESHOT_TCK * TK;
  logic        clk_sys, nrst, wr, rd, cmp_pos, cmp_neg, off_hook;
  logic        onhook_monitor, isolation_link_powerdown, tx_valid;
  logic        sample_valid, ring_indicator_pin_o, ring_indicator_pin_oe;
  logic        interrupt_pin, pin_level, ring_detect_status, p, q;
  logic [1:0]  thr_sel;
  logic [7:0]  addr, wdata, rdata, d;
  logic [15:0] tx_sample, serial_transmit_samples;
  int          failures, checked, seed, n;

  // Open-drain indicator with its pull-up
  assign pin_level = ring_indicator_pin_oe ? ring_indicator_pin_o : 1'b1;

  ring_detect #(.TICK_CYC(TK)) u_dut (.clk_sys, .nrst, .addr, .wdata, .wr,
    .rd, .rdata, .cmp_pos, .cmp_neg, .thr_sel, .off_hook, .onhook_monitor,
    .isolation_link_powerdown, .tx_sample, .tx_valid,
    .serial_transmit_samples, .sample_valid, .ring_indicator_pin_o,
    .ring_indicator_pin_oe, .interrupt_pin);
  ring_host u_host (.clk_sys, .addr, .wdata, .wr, .rd, .rdata);

  task automatic chk(input string s, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  function automatic logic [15:0] exp_sample(logic fw, logic ps, logic ng);
    if (ps) return ring_pkg::SAMPLE_POS;
    if (ng || !fw) return ring_pkg::SAMPLE_NEG;
    return ring_pkg::SAMPLE_IDLE;
  endfunction

  task automatic print_verdict;
    $display("Checks %0d, failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    seed = 32'h0e57;
    {nrst, cmp_pos, cmp_neg, off_hook, onhook_monitor} = '0;
    {isolation_link_powerdown, tx_valid, ring_detect_status} = '0;
    tx_sample = 16'h0000;
    failures = 0;
    checked = 0;
    tick(20);
    nrst <= 1'b1;
    tick(1);
    u_host.bus_write(8'h00, 8'hff);
    for (int a = 0; a < 32; a++) begin
      u_host.bus_read(8'(a), d);
      chk("reset read", 16'h0000, {8'h00, d});
    end
    chk("idle pin", 16'h0001, {15'h0, pin_level});
    for (int i = 0; i < 4; i++) begin
      u_host.bus_write(ring_pkg::REG_THR_LO, 8'(i & 1));
      u_host.bus_write(ring_pkg::REG_THR_HI, 8'((i >> 1) << 4));
      #1 chk("thr_sel", 16'(i), {14'h0, thr_sel});
    end
    u_host.bus_write(ring_pkg::REG_MASK, 8'h80);
    // Hand corners first: a negative-only ring in half-wave sets only the negative flag
    for (int c = 0; c < 4; c++) begin
      u_host.bus_write(ring_pkg::REG_MODE, 8'((c & 1) << 1));
      u_host.bus_write(ring_pkg::REG_PINCFG, 8'(c & 2));
      for (int j = 0; j < 8; j++) begin
        {p, q} = 2'($random(seed));
        if (c == 0 && j < 2) {p, q} = 2'(j + 1);
        q = q & !p;
        cmp_pos <= p;
        cmp_neg <= q;
        tx_sample <= 16'($random(seed));
        if (p || (c[0] && q)) ring_detect_status = 1'b1;
        tick(3);
        #1 chk("pin", {15'h0, (p | (c[0] & q)) ~^ c[1]},
               {15'h0, pin_level});
        chk("sample", exp_sample(c[0], p, q),
            serial_transmit_samples);
        u_host.bus_read(ring_pkg::REG_STAT, d);
        chk("status", {13'h0, ring_detect_status, p, q},
            {13'h0, d[2], d[5], d[6]});
      end
    end
    chk("irq", 16'h0001, {15'h0, interrupt_pin});
    {cmp_pos, cmp_neg} <= 2'b00;
    u_host.bus_write(ring_pkg::REG_INTCFG, 8'h01);
    #1 chk("irq inverted", 16'h0000, {15'h0, interrupt_pin});
    u_host.bus_write(ring_pkg::REG_INTCFG, 8'h00);
    u_host.clear_ring_irq();
    #1 chk("irq cleared", 16'h0000, {15'h0, interrupt_pin});
    off_hook <= 1'b1;
    tick(2);
    u_host.bus_read(ring_pkg::REG_STAT, d);
    chk("off-hook status", 16'h0000, {15'h0, d[2]});
    tx_valid <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      off_hook <= (k == 0);
      onhook_monitor <= (k == 1);
      isolation_link_powerdown <= (k == 2);
      cmp_pos <= 1'b1;
      tx_sample <= 16'($random(seed));
      tick(3);
      #1 chk("passthrough", tx_sample, serial_transmit_samples);
      chk("strobe", 16'h0001, {15'h0, sample_valid});
    end
    {onhook_monitor, isolation_link_powerdown} <= 2'b00;
    tick(3);
    #1 chk("ring data", ring_pkg::SAMPLE_POS, serial_transmit_samples);
    cmp_pos <= 1'b0;
    u_host.bus_write(ring_pkg::REG_CTRL2, 8'h04);
    u_host.clear_ring_irq();
    // Let the pin settle past the clearing edge before the first look
    #1 n = 0;
    while (interrupt_pin !== 1'b1 && n < 2 * OS) begin
      tick(1);
      #1 n++;
    end
    chk("one-shot", 16'h0001, {15'h0, n > OS - 24 && n < OS + 24});
    if (n >= 2 * OS) print_verdict();
    u_host.clear_ring_irq();
    u_host.bus_write(ring_pkg::REG_PINCFG, 8'h00);
    u_host.bus_write(ring_pkg::REG_MODE, 8'h00);
    u_host.bus_write(ring_pkg::REG_HFLIM, 8'h04);
    u_host.bus_write(ring_pkg::REG_DUR, 8'h00);
    u_host.bus_write(ring_pkg::REG_DELAY, 8'h01);
    u_host.bus_write(ring_pkg::REG_LFLIM, 8'h94);
    // Half-period of 1 tick is too fast, 8 ticks lies inside the limits
    for (int h = 1; h < 9; h += 7) begin
      for (int i = 0; i < 40; i++) begin
        cmp_pos <= !i[0];
        cmp_neg <= i[0];
        tick(h * TK);
      end
      u_host.bus_read(ring_pkg::REG_STAT, d);
      #1 chk("validated", {13'h0, h == 8, h == 8, h != 8},
             {13'h0, d[2], interrupt_pin, pin_level});
      {cmp_pos, cmp_neg} <= 2'b00;
      tick(100 * TK);
      u_host.bus_read(ring_pkg::REG_STAT, d);
      chk("ring end", 16'h0000, {15'h0, d[2]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire
